// ---- common/tcw_pkg.sv ----
// Package of constants for the capture/width timer channel
`default_nettype none
package tcw_pkg;
    localparam int          CNT_W         = 16;
    localparam logic [15:0] CNT_CLEAR     = 16'h0000;
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    localparam logic [15:0] CAP_RESET     = 16'h0000;
    localparam int          OVF_BIT       = 0;
    localparam logic [1:0]  EDGE_LOW_W    = 2'h2;
    localparam logic [1:0]  EDGE_HIGH_W   = 2'h3;
    localparam logic [7:0]  PRESCALE_DFLT = 8'h01;
    typedef enum logic [1:0] {TCW_IDLE, TCW_WAIT, TCW_COUNT} tcw_state_t;
endpackage
`default_nettype wire

// ---- logic/tcw_clk_div.sv ----
// Count clock enable divider
`default_nettype none
module tcw_clk_div #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // Control
    input  wire logic         run,
    input  wire logic [W-1:0] divide,
    output var  logic         tick
);
    logic [W-1:0] count;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (!run) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count + W'(1) >= divide) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + W'(1);
            tick  <= 1'b0;
        end
    end
endmodule // tcw_clk_div
`default_nettype wire

// ---- logic/tcw_edge_det.sv ----
// Timer input edge detector
`default_nettype none
module tcw_edge_det (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic clear,
    // Input and edges
    input  wire logic sig_in,
    output var  logic rise,
    output var  logic fall
);
    logic prev;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prev <= 1'b0;
        end else if (clear) begin
            prev <= sig_in;
        end else begin
            prev <= sig_in;
        end
    end

    assign rise = sig_in & ~prev;
    assign fall = ~sig_in & prev;
endmodule // tcw_edge_det
`default_nettype wire

// ---- logic/tcw_channel.sv ----
// One capture channel: pulse interval and level width measurement
// How it works
// - Start trigger sets enable status and, in interval mode, starts counting; trigger self-clears.
// - Interval mode clears counter to zero on first count tick after start.
// - Start-interrupt select set gives a channel interrupt at start.
// - Capture, count and status values are always visible on ports.
// - Interval mode: edge or start trigger captures, clears, interrupts, repeatedly.
// - Interval capture sets overflow if counter wrapped since last capture.
// - Stop trigger clears enable, halts counter, holds count and overflow.
// - Unit clock enable low initializes all channel state.
// - Width mode uses capture one-count mode with an up counter.
// - Width mode start sets enable and waits for start edge without counting.
// - Start edge begins counting from zero; high width starts on rising.
// - Capture edge copies counter and raises interrupt in the same cycle.
// - Width capture sets overflow if the counter wrapped during measurement.
// - After width capture counter stops at captured plus one, then waits again.
// - Overflow is one bit; any number of wraps sets it.
// - Edge select 10 measures low width, 11 measures high width.
// - Width mode ignores start trigger while enable status is set.
// - Timer input sampled on every sys_clk edge, not on the divided operating clock tick; one cycle error.
// - Overflow flag sits at bit 0 of the status value.
`default_nettype none
module tcw_channel #(
    parameter int CNT_W = tcw_pkg::CNT_W,
    parameter int DIV_W = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // Unit control
    input  wire logic             unit_clock_enable,
    input  wire logic [DIV_W-1:0] operating_clock_select,
    // Channel mode
    input  wire logic             width_mode,
    input  wire logic             start_interrupt_select,
    input  wire logic             edge_select_high,
    input  wire logic             edge_select_low,
    // Triggers
    input  wire logic             channel_start_trigger_bit,
    input  wire logic             channel_stop_trigger,
    // Pin
    input  wire logic             timer_input_pin,
    // Status
    output var  logic             channel_enable_status_bit,
    output var  logic [CNT_W-1:0] timer_count_register,
    output var  logic [CNT_W-1:0] capture_data_register,
    output var  logic [7:0]       channel_status_register,
    output var  logic             channel_interrupt
);
    tcw_pkg::tcw_state_t state;
    logic                tick;
    logic                rise;
    logic                fall;
    logic                pin_q;
    logic                wrapped;
    logic                first_tick;
    logic                overflow_flag;
    logic                start_edge;
    logic                cap_edge;
    logic                start_ok;
    logic                stop_ok;
    logic                run;
    logic                measure_high;
    logic                cnt_wrap;

    // Pin sampled on every sys_clk edge, not on the operating clock tick
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= timer_input_pin;
        end
    end

    assign run = unit_clock_enable && channel_enable_status_bit;

    tcw_clk_div #(.W(DIV_W)) u_div (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (run),
        .divide  (operating_clock_select),
        .tick    (tick)
    );

    tcw_edge_det u_edge (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clear   (~unit_clock_enable),
        .sig_in  (pin_q),
        .rise    (rise),
        .fall    (fall)
    );

    assign measure_high = edge_select_high && edge_select_low;
    assign start_edge   = measure_high ? rise : fall;
    assign cap_edge     = measure_high ? fall : rise;
    assign start_ok     = unit_clock_enable && channel_start_trigger_bit
                          && !(width_mode && channel_enable_status_bit);
    assign stop_ok      = unit_clock_enable && channel_stop_trigger;
    assign cnt_wrap     = tick && (timer_count_register == {CNT_W{1'b1}});

    // Enable status and state; triggers are pulses so they read back as 0
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            channel_enable_status_bit <= 1'b0;
            state                     <= tcw_pkg::TCW_IDLE;
        end else if (!unit_clock_enable) begin
            channel_enable_status_bit <= 1'b0;
            state                     <= tcw_pkg::TCW_IDLE;
        end else if (stop_ok) begin
            channel_enable_status_bit <= 1'b0;
            state                     <= tcw_pkg::TCW_IDLE;
        end else begin
            case (state)
                tcw_pkg::TCW_IDLE: begin
                    if (start_ok) begin
                        channel_enable_status_bit <= 1'b1;
                        state <= width_mode ? tcw_pkg::TCW_WAIT : tcw_pkg::TCW_COUNT;
                    end
                end
                tcw_pkg::TCW_WAIT: begin
                    if (start_edge) begin
                        state <= tcw_pkg::TCW_COUNT;
                    end
                end
                tcw_pkg::TCW_COUNT: begin
                    if (width_mode && cap_edge) begin
                        state <= tcw_pkg::TCW_WAIT;
                    end
                end
                default: begin
                    state <= tcw_pkg::TCW_IDLE;
                end
            endcase
        end
    end

    // Counter
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer_count_register <= tcw_pkg::CNT_RESET;
            first_tick           <= 1'b0;
        end else if (!unit_clock_enable) begin
            timer_count_register <= tcw_pkg::CNT_RESET;
            first_tick           <= 1'b0;
        end else if (stop_ok) begin
            first_tick <= 1'b0;
        end else if (state == tcw_pkg::TCW_IDLE && start_ok && !width_mode) begin
            first_tick <= 1'b1;
        end else if (state == tcw_pkg::TCW_WAIT && start_edge) begin
            timer_count_register <= tcw_pkg::CNT_CLEAR;
        end else if (state == tcw_pkg::TCW_COUNT) begin
            if (!width_mode && (rise || fall) && (edge_select_high ? (measure_high ? rise : fall) : rise)) begin
                timer_count_register <= tcw_pkg::CNT_CLEAR;
                first_tick           <= 1'b0;
            end else if (!width_mode && channel_start_trigger_bit) begin
                timer_count_register <= tcw_pkg::CNT_CLEAR;
                first_tick           <= 1'b0;
            end else if (width_mode && cap_edge) begin
                timer_count_register <= timer_count_register + CNT_W'(1);
            end else if (tick && first_tick) begin
                timer_count_register <= tcw_pkg::CNT_CLEAR;
                first_tick           <= 1'b0;
            end else if (tick) begin
                timer_count_register <= timer_count_register + CNT_W'(1);
            end
        end
    end

    // Interval capture event shared by capture, flag and interrupt logic
    logic ivl_cap;
    assign ivl_cap = state == tcw_pkg::TCW_COUNT && !width_mode && unit_clock_enable && !stop_ok
                     && (channel_start_trigger_bit
                         || (edge_select_high ? (measure_high ? rise : fall) : rise));
    logic wid_cap;
    assign wid_cap = state == tcw_pkg::TCW_COUNT && width_mode && cap_edge && unit_clock_enable && !stop_ok;

    // Capture register and overflow flag
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            capture_data_register <= tcw_pkg::CAP_RESET;
            overflow_flag         <= 1'b0;
            wrapped               <= 1'b0;
        end else if (!unit_clock_enable) begin
            capture_data_register <= tcw_pkg::CAP_RESET;
            overflow_flag         <= 1'b0;
            wrapped               <= 1'b0;
        end else if (ivl_cap || wid_cap) begin
            capture_data_register <= timer_count_register;
            overflow_flag         <= wrapped || cnt_wrap;
            wrapped               <= 1'b0;
        end else if (state == tcw_pkg::TCW_WAIT && start_edge) begin
            wrapped <= 1'b0;
        end else if (state == tcw_pkg::TCW_COUNT && cnt_wrap && !first_tick && !stop_ok) begin
            wrapped <= 1'b1;
        end
    end

    // Interrupt pulse
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            channel_interrupt <= 1'b0;
        end else if (!unit_clock_enable || stop_ok) begin
            channel_interrupt <= 1'b0;
        end else if (state == tcw_pkg::TCW_IDLE && start_ok) begin
            channel_interrupt <= start_interrupt_select;
        end else begin
            channel_interrupt <= ivl_cap || wid_cap;
        end
    end

    // Status value, always readable
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            channel_status_register <= 8'h00;
        end else begin
            channel_status_register          <= 8'h00;
            channel_status_register[tcw_pkg::OVF_BIT] <= (ivl_cap || wid_cap) ? (wrapped || cnt_wrap)
                                                                            : overflow_flag;
        end
    end

    property p_stop_clears;
        @(posedge sys_clk) disable iff (reset)
        (unit_clock_enable && channel_stop_trigger) |=> !channel_enable_status_bit;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear enable");

    property p_start_sets;
        @(posedge sys_clk) disable iff (reset)
        (state == tcw_pkg::TCW_IDLE && start_ok && !stop_ok) |=> channel_enable_status_bit;
    endproperty
    a_start_sets: assert property (p_start_sets) else $error("start did not set enable");

    property p_capture_copy;
        @(posedge sys_clk) disable iff (reset)
        wid_cap |=> (capture_data_register == $past(timer_count_register)) && channel_interrupt;
    endproperty
    a_capture_copy: assert property (p_capture_copy) else $error("width capture wrong");

    property p_plus_one;
        @(posedge sys_clk) disable iff (reset)
        wid_cap |=> timer_count_register == capture_data_register + CNT_W'(1);
    endproperty
    a_plus_one: assert property (p_plus_one) else $error("counter not at capture plus one");

    property p_wait_holds;
        @(posedge sys_clk) disable iff (reset)
        (state == tcw_pkg::TCW_WAIT && !start_edge && unit_clock_enable) |=> $stable(timer_count_register);
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("counted while waiting");

    property p_unit_off;
        @(posedge sys_clk) disable iff (reset)
        !unit_clock_enable |=> (timer_count_register == 16'h0000) && !channel_enable_status_bit;
    endproperty
    a_unit_off: assert property (p_unit_off) else $error("unit off did not initialize");

    property p_ignore_restart;
        @(posedge sys_clk) disable iff (reset)
        (width_mode && channel_enable_status_bit && channel_start_trigger_bit && state == tcw_pkg::TCW_WAIT
         && !start_edge && unit_clock_enable && !stop_ok)
        |=> state == tcw_pkg::TCW_WAIT && !channel_interrupt && $stable(timer_count_register);
    endproperty
    a_ignore_restart: assert property (p_ignore_restart) else $error("restart not ignored");

    property p_ivl_clear;
        @(posedge sys_clk) disable iff (reset)
        ivl_cap |=> (timer_count_register == tcw_pkg::CNT_CLEAR) && channel_interrupt
                    && (capture_data_register == $past(timer_count_register));
    endproperty
    a_ivl_clear: assert property (p_ivl_clear) else $error("interval capture did not clear");

    property p_start_irq;
        @(posedge sys_clk) disable iff (reset)
        (state == tcw_pkg::TCW_IDLE && start_ok && !stop_ok) |=> channel_interrupt == $past(start_interrupt_select);
    endproperty
    a_start_irq: assert property (p_start_irq) else $error("start interrupt select not honoured");

    property p_first_clear;
        @(posedge sys_clk) disable iff (reset)
        (!width_mode && state == tcw_pkg::TCW_COUNT && first_tick && tick && unit_clock_enable && !stop_ok)
        |=> timer_count_register == tcw_pkg::CNT_CLEAR;
    endproperty
    a_first_clear: assert property (p_first_clear) else $error("first count tick did not clear");

    property p_stop_holds;
        @(posedge sys_clk) disable iff (reset)
        stop_ok |=> $stable(timer_count_register) && $stable(overflow_flag);
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("stop did not hold count and flag");

    property p_idle_holds;
        @(posedge sys_clk) disable iff (reset)
        (state == tcw_pkg::TCW_IDLE && unit_clock_enable) |=> $stable(timer_count_register);
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("counter moved while stopped");

    property p_wid_ovf_set;
        @(posedge sys_clk) disable iff (reset)
        (wid_cap && wrapped) |=> channel_status_register[tcw_pkg::OVF_BIT];
    endproperty
    a_wid_ovf_set: assert property (p_wid_ovf_set) else $error("wrap not reported as overflow");

    property p_wid_ovf_clear;
        @(posedge sys_clk) disable iff (reset)
        (wid_cap && !wrapped && !cnt_wrap) |=> !channel_status_register[tcw_pkg::OVF_BIT];
    endproperty
    a_wid_ovf_clear: assert property (p_wid_ovf_clear) else $error("overflow set without wrap");
endmodule // tcw_channel
`default_nettype wire

// ---- tb/tcw_pin_model.sv ----
// Pulse source standing in for the signal on the timer input pin
`default_nettype none
module tcw_pin_model (
    // Clock
    input  wire logic        sys_clk,
    // Pulse request
    input  wire logic        go,
    input  wire logic        level,
    input  wire logic [31:0] width,
    // Pin
    output var  logic        pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] left = 32'h0;
    // Pin moves only at clock edges, so sampling error stays within one cycle
    always @(posedge sys_clk) begin
        if (go)
            left <= width;
        else if (left != 32'h0)
            left <= left - 32'h1;
    end
    // Idle at the opposite of the pulse level
    always_comb pin = (left != 32'h0) ? level : ~level;
endmodule // tcw_pin_model
`default_nettype wire

// ---- tb/test_timer_capture_width_interval.sv ----
// Self-checking bench for the capture/width timer channel
`default_nettype none
module test_timer_capture_width_interval;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] P_START = 3'h1;
    localparam logic [2:0] P_STOP  = 3'h2;
    localparam logic [2:0] P_GO    = 3'h4;
    typedef struct packed {logic [15:0] cap; logic ovf; logic chk; logic wid;} tcw_note_t;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        uce     = 1'b0;
    logic [7:0]  ocs     = 8'h01;
    logic        wm      = 1'b1;
    logic        sis     = 1'b0;
    logic        esh     = 1'b1;
    logic        esl     = 1'b1;
    logic        st      = 1'b0;
    logic        sp      = 1'b0;
    logic        go      = 1'b0;
    logic        lvl     = 1'b1;
    logic [31:0] width   = 32'h2;
    logic        pin;
    logic        en;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0]  stat;
    logic        irq;
    logic [15:0] held;
    tcw_note_t   notes[$];
    tcw_note_t   nt;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          seed = 24;
    int          w;
    int          p;
    tcw_channel dut (.sys_clk(sys_clk), .reset(reset), .unit_clock_enable(uce), .operating_clock_select(ocs),
        .width_mode(wm), .start_interrupt_select(sis), .edge_select_high(esh), .edge_select_low(esl),
        .channel_start_trigger_bit(st), .channel_stop_trigger(sp), .timer_input_pin(pin),
        .channel_enable_status_bit(en), .timer_count_register(cnt), .capture_data_register(cap),
        .channel_status_register(stat), .channel_interrupt(irq));
    tcw_pin_model src (.sys_clk(sys_clk), .go(go), .level(lvl), .width(width), .pin(pin));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s, input int tol);
        logic [31:0] d;
        samples_checked++;
        d = (s > e) ? s - e : e - s;
        if ((^s === 1'bx) || (d > tol)) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // One-cycle pulse on go, stop or start, chosen by mask
    task automatic pulse(input logic [2:0] m);
        @(posedge sys_clk);
        {go, sp, st} <= m;
        @(posedge sys_clk);
        {go, sp, st} <= 3'h0;
    endtask
    task automatic note(input int c, input bit chk, input bit wid);
        tcw_note_t n;
        n.cap = 16'(c);
        n.ovf = (c > 65535);
        n.chk = chk;
        n.wid = wid;
        notes.push_back(n);
    endtask
    // Width pulse of w count clocks, capture is w minus one
    task automatic wpulse(input int pw);
        note(pw - 1, 1'b1, 1'b1);
        width <= 32'(pw);
        pulse(P_GO);
        tick(pw + 8);
    endtask
    task automatic zeros();
        check("channel_enable_status_bit", 32'h0, {31'h0, en}, 0);
        check("timer_count_register", 32'h0, {16'h0, cnt}, 0);
        check("capture_data_register", 32'h0, {16'h0, cap}, 0);
        check("channel_status_register", 32'h0, {24'h0, stat}, 0);
    endtask
    // Each interrupt takes the oldest note
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_fail++;
            test_done();
        end else if (irq === 1'b1) begin
            if (notes.size() == 0)
                check("channel_interrupt", 32'h0, 32'h1, 0);
            else begin
                nt = notes.pop_front();
                if (nt.chk) begin
                    check("capture_data_register", {16'h0, nt.cap}, {16'h0, cap}, 1);
                    check("channel_status_register", {31'h0, nt.ovf}, {24'h0, stat}, 0);
                end
                if (nt.chk && nt.wid)
                    check("timer_count_register", {16'h0, nt.cap} + 32'h1, {16'h0, cnt}, 1);
            end
        end
    end
    initial begin
        tick(3);
        reset <= 1'b0;
        tick(1);
        zeros();
        uce <= 1'b1;
        // High width: 11 on the edge select bits
        pulse(P_START);
        tick(4);
        check("channel_enable_status_bit", 32'h1, {31'h0, en}, 0);
        check("timer_count_register", 32'h0, {16'h0, cnt}, 0);
        for (int i = 0; i < 3; i++) begin
            w = 5 + ($unsigned($random(seed)) % 40);
            wpulse(w);
        end
        pulse(P_START);
        tick(5);
        check("channel_enable_status_bit", 32'h1, {31'h0, en}, 0);
        check("timer_count_register", 32'(w), {16'h0, cnt}, 1);
        pulse(P_STOP);
        tick(3);
        // Mode bits change only while stopped
        esl <= 1'b0;
        lvl <= 1'b0;
        tick(3);
        pulse(P_START);
        tick(4);
        wpulse(5 + ($unsigned($random(seed)) % 40));
        wpulse(65556);
        wpulse(7);
        pulse(P_STOP);
        tick(3);
        // Pulse interval on rising edges
        wm <= 1'b0;
        esh <= 1'b0;
        esl <= 1'b0;
        sis <= 1'b1;
        lvl <= 1'b1;
        width <= 32'h2;
        tick(3);
        note(0, 1'b0, 1'b0);
        pulse(P_START);
        tick(4);
        check("channel_enable_status_bit", 32'h1, {31'h0, en}, 0);
        // Cleared on the first count clock, one count since
        check("timer_count_register", 32'h1, {16'h0, cnt}, 1);
        p = 20 + ($unsigned($random(seed)) % 30);
        for (int i = 0; i < 4; i++) begin
            note(p - 1, i > 0, 1'b0);
            pulse(P_GO);
            tick(p - 2);
        end
        note(0, 1'b0, 1'b0);
        pulse(P_START);
        tick(1);
        check("timer_count_register", 32'h0, {16'h0, cnt}, 0);
        pulse(P_STOP);
        tick(3);
        check("channel_enable_status_bit", 32'h0, {31'h0, en}, 0);
        held = cnt;
        tick(10);
        check("timer_count_register", {16'h0, held}, {16'h0, cnt}, 0);
        check("channel_status_register", 32'h0, {24'h0, stat}, 0);
        check("pending_notes", 32'h0, 32'(notes.size()), 0);
        uce <= 1'b0;
        tick(3);
        zeros();
        test_done();
    end
endmodule // test_timer_capture_width_interval
`default_nettype wire
